// File: numeric_entry_notify.sv
// numeric entry notify: writes table index then strobe into host memory
//
// Operation
// RQ1: set strobe flag when entry completes
// RQ2: write changed table index to table word
// RQ3: index coded as three bcd digits
// RQ4: clear strobe after it was delivered
// RQ5: host samples index on strobe rising edge
// RQ6: host keeps area out of timer/counter
// RQ7: host then reads the table's own word
// RQ8: reported indices stay within 000 to 511
// RQ9: index written before strobe rises
`timescale 1ns/1ps
module numeric_entry_notify
  import entry_notify_pkg::*;
(
  // clock and reset
  input  wire logic                                  ref_clk,
  input  wire logic                                  nrst,
  // operator entry event
  input  wire logic                                  entry_done,
  input  wire logic [entry_notify_pkg::TABLE_W-1:0]  entry_table,
  // base of the notify area in host memory
  input  wire logic [entry_notify_pkg::ADDR_W-1:0]   area_base,
  // host memory write port (serial link framer behind it)
  output logic                                       wr_req,
  output logic [entry_notify_pkg::ADDR_W-1:0]        wr_addr,
  output logic [entry_notify_pkg::WORD_W-1:0]        wr_data,
  input  wire logic                                  wr_ack,
  // status
  output logic                                       busy,
  output logic                                       entry_dropped
);
  typedef enum logic [2:0] {
    S_IDLE, S_CONV, S_WR_TABLE, S_WR_SET, S_HOLD, S_WR_CLR
  } state_t;

  // report sequencer
  state_t              state_r;
  state_t              state_nxt;
  // one-deep entry holding stage
  logic                pend_r;
  logic [TABLE_W-1:0]  pend_tab_r;
  // entry being reported
  logic [TABLE_W-1:0]  cur_tab_r;
  logic [7:0]          hold_r;
  // converter handshake
  logic                conv_go_r;
  logic                conv_done;
  logic [BCD_W-1:0]    conv_bcd;
  // decoded events
  logic                entry_ok;
  logic                take_pend;
  logic                ack_seen;
  logic                hold_last;

  // the bound never rejects a 9-bit index; it pins down the legal range
  assign entry_ok  = entry_done && (entry_table <= TABLE_MAX); // [RQ8]
  assign take_pend = (state_r == S_IDLE) && pend_r;
  // a write counts as taken only on an edge where request and ack meet
  assign ack_seen  = wr_req && wr_ack;
  assign hold_last = (hold_r == 8'h01);

  bin_to_bcd u_conv (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .start   (conv_go_r),
    .bin_in  (cur_tab_r),
    .done    (conv_done),
    .bcd_out (conv_bcd)
  );

  function automatic logic [ADDR_W-1:0] area_addr(
    input logic [ADDR_W-1:0] base, input logic [ADDR_W-1:0] ofs);
    area_addr = ADDR_W'(base + ofs);
  endfunction

  // one entry may wait while another is being reported; a later one
  // replaces it, since the host only needs the newest table per edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pend_r     <= 1'b0;
      pend_tab_r <= '0;
    end else begin
      if (entry_ok) begin
        pend_r     <= 1'b1;
        pend_tab_r <= entry_table;
      end else if (take_pend) begin
        pend_r <= 1'b0;
      end
    end
  end

  // a hand-over in idle is no loss: the old entry leaves as the new one
  // arrives, so only an overwrite while reporting is flagged
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      entry_dropped <= 1'b0;
    end else begin
      entry_dropped <= entry_ok && pend_r && (state_r != S_IDLE);
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (pend_r) begin
          state_nxt = S_CONV;
        end
      end
      S_CONV: begin
        if (conv_done) begin
          state_nxt = S_WR_TABLE;
        end
      end
      S_WR_TABLE: begin
        if (ack_seen) begin // [RQ9]
          state_nxt = S_WR_SET;
        end
      end
      S_WR_SET: begin
        if (ack_seen) begin
          state_nxt = S_HOLD;
        end
      end
      S_HOLD: begin
        if (hold_last) begin
          state_nxt = S_WR_CLR;
        end
      end
      S_WR_CLR: begin
        if (ack_seen) begin
          state_nxt = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one start pulse per entry: a level start would relaunch the converter
  // on the edge it finishes and leave a stray done pulse behind
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      conv_go_r <= 1'b0;
    end else begin
      conv_go_r <= take_pend;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cur_tab_r <= '0;
    end else if (take_pend) begin
      cur_tab_r <= pend_tab_r;
    end
  end

  // write port: index word, strobe set, pause, strobe clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_req  <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          wr_req <= 1'b0;
        end
        S_CONV: begin
          if (conv_done) begin
            wr_req  <= 1'b1;
            wr_addr <= area_addr(area_base, OFS_TABLE_WORD);
            wr_data <= {{(WORD_W-BCD_W){1'b0}}, conv_bcd}; // [RQ2] [RQ3]
          end
        end
        S_WR_TABLE: begin
          // strobe write only after the index write was taken
          if (ack_seen) begin // [RQ9]
            wr_addr <= area_addr(area_base, OFS_FLAG_WORD);
            wr_data <= STROBE_SET; // [RQ1]
          end
        end
        S_WR_SET: begin
          if (ack_seen) begin
            wr_req <= 1'b0;
          end
        end
        S_HOLD: begin
          // address still points at the flag word
          if (hold_last) begin
            wr_req  <= 1'b1;
            wr_data <= STROBE_CLR; // [RQ4]
          end
        end
        S_WR_CLR: begin
          if (ack_seen) begin
            wr_req <= 1'b0;
          end
        end
      endcase
    end
  end

  // keep the strobe high long enough for a scanning host to see the edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold_r <= 8'h00;
    end else if (state_r == S_WR_SET && ack_seen) begin
      hold_r <= HOLD_CYC_W;
    end else if (state_r == S_HOLD) begin
      hold_r <= 8'(hold_r - 8'h01);
    end
  end

  // busy spans the whole report, from taking the entry to the clear ack
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else if (take_pend) begin
      busy <= 1'b1;
    end else if (state_r == S_WR_CLR && ack_seen) begin
      busy <= 1'b0;
    end
  end
endmodule

// File: entry_notify_pkg.sv
// constants for the numeric entry notify block
package entry_notify_pkg;
  localparam int unsigned TABLE_W       = 9;
  localparam logic [8:0]  TABLE_MAX     = 9'h1FF;
  localparam int unsigned BCD_W         = 12;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned ADDR_W        = 16;
  localparam logic [3:0]  STROBE_BIT    = 4'hB;
  localparam logic [15:0] STROBE_SET    = 16'h0800;
  localparam logic [15:0] STROBE_CLR    = 16'h0000;
  localparam logic [15:0] OFS_FLAG_WORD = 16'h0000;
  localparam logic [15:0] OFS_TABLE_WORD = 16'h0001;
  localparam logic [3:0]  DIGIT_TEN     = 4'hA;
  localparam int unsigned CONV_STEPS    = 9;
  // minimum strobe high time so the controller's scan sees the edge
  localparam int unsigned HOLD_NS       = 1000;
  localparam int unsigned CLK_NS        = 100;
  localparam int unsigned HOLD_CYC      = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  HOLD_CYC_W    = 8'(HOLD_CYC);
endpackage

// File: bin_to_bcd.sv
// sequential binary to three digit bcd converter (double dabble)
`timescale 1ns/1ps
module bin_to_bcd
  import entry_notify_pkg::*;
(
  // clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            nrst,
  // request
  input  wire logic                            start,
  input  wire logic [entry_notify_pkg::TABLE_W-1:0] bin_in,
  // result
  output logic                                 done,
  output logic [entry_notify_pkg::BCD_W-1:0]   bcd_out
);
  logic [TABLE_W-1:0] shreg_r;
  logic [BCD_W-1:0]   acc_r;
  logic [3:0]         step_r;
  logic               busy_r;

  function automatic logic [3:0] adj(input logic [3:0] d);
    adj = (d >= 4'h5) ? 4'(d + 4'h3) : d;
  endfunction

  logic [BCD_W-1:0] acc_adj;
  always_comb begin
    acc_adj = {adj(acc_r[11:8]), adj(acc_r[7:4]), adj(acc_r[3:0])};
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      shreg_r <= '0;
      acc_r   <= '0;
      step_r  <= 4'h0;
      busy_r  <= 1'b0;
      done    <= 1'b0;
      bcd_out <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy_r) begin
        shreg_r <= bin_in;
        acc_r   <= '0;
        step_r  <= 4'h0;
        busy_r  <= 1'b1;
      end else if (busy_r) begin
        acc_r   <= {acc_adj[BCD_W-2:0], shreg_r[TABLE_W-1]};
        shreg_r <= {shreg_r[TABLE_W-2:0], 1'b0};
        step_r  <= 4'(step_r + 4'h1);
        if (step_r == 4'(CONV_STEPS - 1)) begin
          busy_r  <= 1'b0;
          done    <= 1'b1;
          bcd_out <= {acc_adj[BCD_W-2:0], shreg_r[TABLE_W-1]}; // [RQ3]
        end
      end
    end
  end
endmodule

// File: notify_checker.sv
// assertions on the entry notify write stream
`timescale 1ns/1ps
module notify_checker
  import entry_notify_pkg::*;
(
  // clock and reset
  input wire logic                                  ref_clk,
  input wire logic                                  nrst,
  // entry side
  input wire logic                                  entry_done,
  input wire logic [entry_notify_pkg::TABLE_W-1:0]  entry_table,
  input wire logic [entry_notify_pkg::ADDR_W-1:0]   area_base,
  // host write port
  input wire logic                                  wr_req,
  input wire logic [entry_notify_pkg::ADDR_W-1:0]   wr_addr,
  input wire logic [entry_notify_pkg::WORD_W-1:0]   wr_data,
  input wire logic                                  wr_ack,
  // status
  input wire logic                                  busy,
  input wire logic                                  entry_dropped
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic tw, sw, go;
  assign tw = wr_req && wr_addr == area_base + 16'h0001;
  assign sw = wr_req && wr_addr == area_base && wr_data == STROBE_SET;
  assign go = entry_done && !busy;
  tbl_first_a: assert property (go |-> ##[2:20] tw)
    else $error("no table write");
  strobe_set_a: assert property (go |-> ##[8:60] sw)
    else $error("no strobe set");
  tbl_before_a: assert property ($rose(sw) |-> $past(tw && wr_ack))
    else $error("strobe before table");
  bcd_form_a: assert property (tw |-> wr_data[15:12] == 4'h0
    && wr_data[11:8] < 4'h6 && wr_data[7:4] < DIGIT_TEN
    && wr_data[3:0] < DIGIT_TEN) else $error("bad bcd index");
  strobe_clr_a: assert property (sw && wr_ack |=> !wr_req [*8]
    ##[2:20] wr_req && wr_addr == area_base && wr_data == STROBE_CLR)
    else $error("strobe not cleared");
  req_hold_a: assert property (wr_req && !wr_ack |=> wr_req
    && $stable(wr_data) && $stable(wr_addr)) else $error("write moved");
  cover property (sw && wr_ack);
  cover property (entry_dropped);
  cover property (tw && wr_data[11:8] == 4'h5);
  cover property (entry_done && entry_table == TABLE_MAX);
endmodule
bind numeric_entry_notify notify_checker u_chk (.ref_clk, .nrst,
  .entry_done, .wr_req, .wr_ack, .busy, .entry_dropped, .entry_table,
  .area_base, .wr_addr, .wr_data);

// File: host_mem_model.sv
// host memory model: acks writes, watches the strobe flag
`timescale 1ns/1ps
module host_mem_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // write port from the block
  input  wire logic        wr_req,
  input  wire logic [15:0] wr_addr,
  input  wire logic [15:0] wr_data,
  output logic             wr_ack,
  // test control and observations
  input  wire logic        slow,
  output logic [15:0]      seen,
  output logic [15:0]      flag,
  output logic [7:0]       edges
);
  logic [15:0] tbl;
  logic [2:0]  wait_r;
  logic        old_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      {wait_r, wr_ack, old_r, flag, edges} <= '0;
    end else begin
      wait_r <= (wr_req && !wr_ack) ? wait_r + 3'h1 : 3'h0;
      wr_ack <= wr_req && !wr_ack && wait_r >= {slow, 2'h0};
      if (wr_req && wr_ack) begin
        if (wr_addr[0]) tbl <= wr_data;
        else flag <= wr_data;
      end
      old_r <= flag[11];
      // a stale index shows up here if the flag beat the table word
      if (flag[11] && !old_r) begin
        seen <= tbl;
        edges <= edges + 8'h1;
      end
    end
  end
endmodule

// File: test_numeric_entry_notify.sv
// self-checking bench for the numeric entry notify block
`timescale 1ns/1ps
module test_numeric_entry_notify;
  import entry_notify_pkg::*;
  logic ref_clk, nrst, entry_done, slow, wr_req, wr_ack, busy, drp;
  logic [8:0]  entry_table;
  logic [15:0] wr_addr, wr_data, seen, flag;
  logic [7:0]  edges, e0, drops, d0;
  int err_count, checks;
  localparam logic [15:0] BASE = 16'h0110;
  numeric_entry_notify u_dut (.ref_clk, .nrst, .entry_done, .entry_table,
    .area_base(BASE), .wr_req, .wr_addr, .wr_data, .wr_ack, .busy,
    .entry_dropped(drp));
  host_mem_model u_host (.ref_clk, .nrst, .wr_req, .slow, .wr_addr,
    .wr_data, .wr_ack, .seen, .flag, .edges);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // drop pulses last one cycle, so they are counted as they pass
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      drops <= 8'h00;
    else if (drp === 1'b1)
      drops <= 8'(drops + 8'h01);
  end
  task automatic chk(input string what, input logic [15:0] exp, got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic pulse(input logic [8:0] t);
    entry_table = t;
    entry_done = 1'b1;
    @(negedge ref_clk) entry_done = 1'b0;
  endtask
  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(negedge ref_clk);
    while (busy !== 1'b0 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 500) begin
      err_count++;
      summarize();
    end
  endtask
  function automatic logic [15:0] bcd(input int t);
    return {4'h0, 4'(t / 100), 4'(t / 10 % 10), 4'(t % 10)};
  endfunction
  task automatic test_values();
    int v[7] = '{0, 9, 10, 99, 100, 345, 511};
    foreach (v[i]) begin
      slow = i[0];
      e0 = edges;
      pulse(9'(v[i]));
      settle();
      chk("table", bcd(v[i]), seen);
      chk("edges", {8'h0, e0 + 8'h1}, {8'h0, edges});
      chk("flag", STROBE_CLR, flag);
    end
    $display("test_values done");
  endtask
  task automatic test_drop();
    e0 = edges;
    d0 = drops;
    pulse(9'd5);
    repeat (2) @(negedge ref_clk);
    pulse(9'd6);
    @(negedge ref_clk);
    pulse(9'd7);
    settle();
    settle();
    chk("table", bcd(7), seen);
    chk("edges", {8'h0, e0 + 8'h2}, {8'h0, edges});
    chk("dropped", {8'h0, d0 + 8'h1}, {8'h0, drops});
    $display("test_drop done");
  endtask
  initial begin
    {nrst, entry_done, slow} = '0;
    entry_table = '0;
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    test_values();
    test_drop();
    summarize();
  end
endmodule
